// ==== bmx_pkg.sv ====
// package for the bank mux source enable block
package bmx_pkg;
  localparam logic [11:0] ADDR_ENABLE = 12'h000; // gate register
  localparam logic [11:0] ADDR_MODE   = 12'h004; // bank 4..6 mode and selectors
  localparam logic [31:0] ENABLE_RESET = 32'hFFFFE000;
  localparam logic [31:0] ENABLE_MASK  = 32'hFFFFE000; // bits 12..0 lie elsewhere
  localparam int BIT_XO_B5    = 31;
  localparam int BIT_REF2_B6  = 30;
  localparam int BIT_REF2_B5  = 29;
  localparam int BIT_REF2_B4  = 28;
  localparam int BIT_REF0_B6  = 27;
  localparam int BIT_REF0_B5  = 26;
  localparam int BIT_REF0_B4  = 25;
  localparam int BIT_FRAC2_B6 = 24;
  localparam int BIT_FRAC2_B5 = 23;
  localparam int BIT_FRAC2_B4 = 22;
  localparam int BIT_FRAC1_B6 = 20;
  localparam int BIT_FRAC1_B5 = 19;
  localparam int BIT_FRAC1_B4 = 18;
  // mode register layout, one byte per bank 4..6 at byte (bank-4)
  localparam int MODE_AUTO_BIT = 7;  // auto fanout buffer mode
  localparam int MODE_FAN_LSB  = 4;  // fanout source selector, 2 bits
  localparam int MODE_SRC_LSB  = 0;  // output source selector, 3 bits
  localparam logic [1:0] FAN_REF0  = 2'h1;
  localparam logic [1:0] FAN_REF2  = 2'h2;
  localparam logic [2:0] SRC_FRAC1 = 3'h5;
  localparam logic [2:0] SRC_FRAC2 = 3'h6;
  localparam logic [23:0] MODE_RESET = 24'h000000;
  localparam logic [23:0] MODE_MASK  = 24'hB7B7B7;
endpackage

// ==== bmx_bank_auto.sv ====
// per-bank automatic takeover decode for banks 4..6
`timescale 1ns/100ps
module bmx_bank_auto
  import bmx_pkg::*;
(
  input  wire logic [7:0] i_mode,
  output logic            o_own_ref0,
  output logic            o_own_ref2,
  output logic            o_own_frac1,
  output logic            o_own_frac2,
  output logic            o_sel_ref0,
  output logic            o_sel_ref2,
  output logic            o_sel_frac1,
  output logic            o_sel_frac2
);
  logic       auto_on;
  logic [1:0] fan_sel;
  logic [2:0] src_sel;
  // field extraction
  assign auto_on = i_mode[MODE_AUTO_BIT];
  assign fan_sel = i_mode[MODE_FAN_LSB +: 2];
  assign src_sel = i_mode[MODE_SRC_LSB +: 3];
  // ownership by selector value
  assign o_own_ref2  = auto_on & (fan_sel == FAN_REF2);
  assign o_own_ref0  = auto_on & (fan_sel == FAN_REF0);
  assign o_own_frac2 = auto_on & (src_sel == SRC_FRAC2);
  assign o_own_frac1 = auto_on & (src_sel == SRC_FRAC1);
  // mux selection value: the selected source is enabled
  assign o_sel_ref2  = o_own_ref2;
  assign o_sel_ref0  = o_own_ref0;
  assign o_sel_frac2 = o_own_frac2;
  assign o_sel_frac1 = o_own_frac1;
endmodule

// ==== bmx_top.sv ====
// apb register block for bank mux source enables
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module bmx_top
  import bmx_pkg::*;
(
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_SRST,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic      [31:0] O_GATES,
  output logic      [23:0] O_BANK_MODE
);
  logic [31:0] sw_gates;
  logic [31:0] own_mask;
  logic [31:0] own_val;
  logic [31:0] next_gates;
  logic [23:0] mode;
  logic [3:0]  own [3];
  logic [3:0]  sel [3];
  logic        wr_acc;
  logic        rd_setup;
  logic        hit;
  logic [31:0] eff_gates;

  // register decode, shared by write, read and error paths
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] reg_addr);
    return a == reg_addr;
  endfunction

  // takeover decode for banks 4, 5, 6
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_bank
      bmx_bank_auto u_auto (
        .i_mode      (mode[8*g +: 8]),
        .o_own_ref0  (own[g][0]),
        .o_own_ref2  (own[g][1]),
        .o_own_frac1 (own[g][2]),
        .o_own_frac2 (own[g][3]),
        .o_sel_ref0  (sel[g][0]),
        .o_sel_ref2  (sel[g][1]),
        .o_sel_frac1 (sel[g][2]),
        .o_sel_frac2 (sel[g][3])
      );
    end
  endgenerate

  // hardware owned bits; banks 0..3 never appear here
  always_comb
  begin
    own_mask = 32'h00000000;
    own_val  = 32'h00000000;
    own_mask[BIT_REF2_B4]  = own[0][1];
    own_mask[BIT_REF2_B5]  = own[1][1];
    own_mask[BIT_REF2_B6]  = own[2][1];
    own_mask[BIT_REF0_B4]  = own[0][0];
    own_mask[BIT_REF0_B5]  = own[1][0];
    own_mask[BIT_REF0_B6]  = own[2][0];
    own_mask[BIT_FRAC2_B4] = own[0][3];
    own_mask[BIT_FRAC2_B5] = own[1][3];
    own_mask[BIT_FRAC2_B6] = own[2][3];
    own_mask[BIT_FRAC1_B4] = own[0][2];
    own_mask[BIT_FRAC1_B5] = own[1][2];
    own_mask[BIT_FRAC1_B6] = own[2][2];
    own_val[BIT_REF2_B4]   = sel[0][1];
    own_val[BIT_REF2_B5]   = sel[1][1];
    own_val[BIT_REF2_B6]   = sel[2][1];
    own_val[BIT_REF0_B4]   = sel[0][0];
    own_val[BIT_REF0_B5]   = sel[1][0];
    own_val[BIT_REF0_B6]   = sel[2][0];
    own_val[BIT_FRAC2_B4]  = sel[0][3];
    own_val[BIT_FRAC2_B5]  = sel[1][3];
    own_val[BIT_FRAC2_B6]  = sel[2][3];
    own_val[BIT_FRAC1_B4]  = sel[0][2];
    own_val[BIT_FRAC1_B5]  = sel[1][2];
    own_val[BIT_FRAC1_B6]  = sel[2][2];
  end

  // apb access strobe, zero wait states
  assign wr_acc    = i_psel & i_penable & i_pwrite;
  assign rd_setup  = i_psel & ~i_penable & ~i_pwrite;
  assign hit       = addr_is(i_paddr, ADDR_ENABLE) | addr_is(i_paddr, ADDR_MODE);
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~hit;

  // software value; owned bits ignore writes
  always_comb
  begin
    next_gates = sw_gates;
    if (wr_acc && addr_is(i_paddr, ADDR_ENABLE))
      next_gates = (i_pwdata & ENABLE_MASK & ~own_mask) | (sw_gates & own_mask);
  end

  // gate register, all documented bits default enabled
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SRST)
      sw_gates <= ENABLE_RESET;
    else
      sw_gates <= next_gates;
  end

  // bank mode register
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SRST)
      mode <= MODE_RESET;
    else if (wr_acc && addr_is(i_paddr, ADDR_MODE))
      mode <= i_pwdata[23:0] & MODE_MASK;
  end

  // effective gates: hardware value where owned
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SRST)
      O_GATES <= ENABLE_RESET;
    else
      O_GATES <= (next_gates & ~own_mask) | own_val;
  end

  assign O_BANK_MODE = mode;

  // effective gates from the current software value and current mode
  assign eff_gates = (sw_gates & ~own_mask) | own_val;

  // read data from a flop, loaded at the setup edge so it stands through the access phase
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_SRST)
      o_prdata <= 32'h00000000;
    else if (rd_setup && addr_is(i_paddr, ADDR_ENABLE))
      o_prdata <= eff_gates;
    else if (rd_setup && addr_is(i_paddr, ADDR_MODE))
      o_prdata <= {8'h00, mode};
    else if (rd_setup)
      o_prdata <= 32'h00000000;
  end
endmodule

// ==== bmx_top_assertions.sv ====
// bank mux gate register checker
`timescale 1ns/100ps
module bmx_top_assertions
  import bmx_pkg::*;
(
  input wire logic        I_CLK_SYS,
  input wire logic        I_SRST,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pslverr,
  input wire logic [31:0] O_GATES,
  input wire logic [23:0] O_BANK_MODE
);
  localparam logic [31:0] LM = 32'h0023E000;
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SRST);
  // gate register access decode
  wire logic        acc = i_psel & i_penable & (i_paddr == ADDR_ENABLE);
  wire logic [23:0] m   = O_BANK_MODE;
  AST_RESET: assert property ($past(I_SRST) |-> O_GATES == ENABLE_RESET) else $error("reset");
  AST_XO_RW: assert property (acc && i_pwrite |=> O_GATES[31] == $past(i_pwdata[31])) else $error("b31");
  AST_LOW_RW: assert property (acc && i_pwrite |=> (O_GATES & LM) == ($past(i_pwdata) & LM)) else $error("lo");
  AST_READ: assert property (acc && !i_pwrite |-> o_prdata == O_GATES) else $error("read");
  AST_REF2_B4: assert property ($stable(m) && m[7] && m[5:4] == FAN_REF2 |-> O_GATES[28]) else $error("r2");
  AST_REF0_B5: assert property ($stable(m) && m[15] && m[13:12] == FAN_REF0 |-> O_GATES[26]) else $error("r0");
  AST_FRAC2_B5: assert property ($stable(m) && m[15] && m[10:8] == SRC_FRAC2 |-> O_GATES[23]) else $error("f2");
  AST_FRAC1_B6: assert property ($stable(m) && m[23] && m[18:16] == SRC_FRAC1 |-> O_GATES[20]) else $error("f1");
  AST_FRAC2_B4: assert property ($stable(m) && m[7] && m[2:0] == SRC_FRAC2 |-> O_GATES[22]) else $error("f2b4");
  AST_REF2_B6: assert property ($stable(m) && m[23] && m[21:20] == FAN_REF2 |-> O_GATES[30]) else $error("r2b6");
  AST_SLVERR: assert property (i_psel && i_penable |-> o_pslverr == (i_paddr != ADDR_ENABLE && i_paddr != ADDR_MODE))
    else $error("slverr");
  // main scenarios reached
  cover property (acc && i_pwrite);
  cover property (acc && !i_pwrite);
  cover property (m[15] && m[10:8] == SRC_FRAC2);
  cover property (m[7] && m[5:4] == FAN_REF2);
endmodule
bind bmx_top bmx_top_assertions u_chk (.I_CLK_SYS(I_CLK_SYS), .I_SRST(I_SRST), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
  .O_GATES(O_GATES),
  .O_BANK_MODE(O_BANK_MODE));

// ==== bmx_top_tb.sv ====
// self-checking bench for the bank mux gate register
`timescale 1ns/100ps
module bmx_top_tb;
  import bmx_pkg::*;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, rdy, err;
  logic [11:0] adr = 0;
  logic [31:0] wd  = 0, rd, gts, sw = ENABLE_RESET;
  logic [23:0] bm, md = 0;
  logic [7:0]  mv [3] = '{8'h96, 8'hA5, 8'h26};
  int          fails = 0, tests_run = 0, cyc = 0;
  bmx_top u_dut (.I_CLK_SYS(clk), .I_SRST(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(adr),
    .i_pwdata(wd), .o_prdata(rd), .o_pready(rdy), .o_pslverr(err), .O_GATES(gts), .O_BANK_MODE(bm));
  initial forever #5 clk = ~clk;
  // hang guard
  always @(posedge clk)
  begin
    if (++cyc > 5000)
    begin
      fails++;
      end_sim();
    end
  end
  // gates taken over by hardware in the model
  function automatic logic [31:0] own();
    own = 0;
    for (int k = 0; k < 3; k++)
    begin
      if (md[8*k+7] && md[8*k+4+:2] == FAN_REF0) own[25+k] = 1;
      if (md[8*k+7] && md[8*k+4+:2] == FAN_REF2) own[28+k] = 1;
      if (md[8*k+7] && md[8*k+:3] == SRC_FRAC1) own[18+k] = 1;
      if (md[8*k+7] && md[8*k+:3] == SRC_FRAC2) own[22+k] = 1;
    end
  endfunction
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      fails++;
      $display("MISMATCH %0t seen %h want %h", $time, s, e);
    end
  endtask
  // one apb transfer, then model update and port compare
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic [31:0] o;
    o = own();
    psel <= 1;
    pwr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (rdy !== 1'b1);
    chk({31'h0, err}, {31'h0, a != ADDR_ENABLE && a != ADDR_MODE});
    if (!w && a == ADDR_ENABLE) chk(rd, sw | o);
    if (!w && a == ADDR_MODE) chk(rd, {8'h0, md});
    if (w && a == ADDR_ENABLE) sw = (d & ENABLE_MASK & ~o) | (sw & o);
    if (w && a == ADDR_MODE) md = d[23:0] & MODE_MASK;
    psel <= 0;
    pen <= 0;
    repeat (2) @(posedge clk);
    chk(gts, sw | own());
    chk({8'h0, bm}, {8'h0, md});
  endtask
  task end_sim();
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    void'($urandom(41451));
    repeat (2) @(posedge clk);
    rst <= 0;
    apb(0, ADDR_ENABLE, 0);
    $display("test reset done");
    for (int i = 0; i < 9; i++)
    begin
      apb(1, ADDR_MODE, 32'(mv[i%3]) << (8*(i/3)));
      apb(1, ADDR_ENABLE, 0);
      apb(0, ADDR_ENABLE, 0);
      apb(1, ADDR_MODE, 0);
      apb(0, ADDR_ENABLE, 0);
    end
    $display("test takeover done");
    repeat (60) apb(1'($urandom), 12'($urandom % 3 * 4), $urandom);
    $display("test random done");
    end_sim();
  end
endmodule
